// ### hw/t3c_top.sv
// timer three: 16-bit timer/counter with capture, auto-reload and baud clock
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - counter overflow sets overflow flag bit 7; it stays until software clears it.
// - overflow flag never set while receive or transmit clock select is 1.
// - trigger-pin capture or reload with trigger enable sets external flag bit 6.
// - external flag raises the timer interrupt; software clears the flag.
// - in up/down mode the external flag raises no interrupt.
// - receive clock select bit 5 picks this timer's overflows for serial receive in serial modes 1 and 3.
// - transmit clock select bit 4 picks this timer's overflows for serial transmit in serial modes 1 and 3.
// - trigger enable bit 3 admits trigger-pin falling edges unless clocking serial or in up/down mode.
// - run control bit 2 starts the counter when 1, stops it when 0.
// - count source bit 1: internal timing at 0, count-pin falling edges at 1.
// - capture select 1 with trigger enabled captures on trigger falling edge.
// - capture select 0 reloads on overflow, and on trigger edges when enabled.
// - with a serial clock select set, always reload on overflow.
// - reload/capture high and low bytes form the 16-bit reload or capture value.
// - control register at 0C8H, bit addressable, resets to zero.
// - trigger pin is capture/reload trigger and direction input.
// - count pin is event counter input and may drive a clock out.
module t3c_top (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// special-function register bus
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic sfr_bit_wr,
	input wire logic [2:0] sfr_bit_sel,
	input wire logic sfr_bit_val,
	output logic [7:0] sfr_rdata,
	// pins
	input wire logic trigger_pin,
	input wire logic count_pin_in,
	output logic count_pin_out,
	output logic count_pin_oe,
	// serial port and other timer
	input wire logic [1:0] serial_mode,
	input wire logic timer1_ovf,
	output logic rx_baud_tick,
	output logic tx_baud_tick,
	// interrupt request
	output logic timer_irq
);
	logic [7:0] ctl_reg, ctl_next, mode_reg, mode_next;
	logic [15:0] cnt_reg, cnt_next, rcap_reg, rcap_next;
	logic [3:0] pre_reg, pre_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rx_reg, rx_next, tx_reg, tx_next, irq_reg, irq_next, cko_reg, cko_next;
	logic trig_level, trig_fall, cpin_fall;
	logic rx_sel, tx_sel, exen, run, cts, cprl, ud_en, ckoe, baud, serial_13;
	logic pre_tick, count_evt, dir_up, ovf, unf, trig_evt, reload, capture;
	logic [7:0] ctl_sw;

	// pin synchronisers
	t3c_edge_sync u_trig_sync (
		.clk(clk),
		.arst_n(arst_n),
		.pin(trigger_pin),
		.level(trig_level),
		.fall(trig_fall)
	);
	t3c_edge_sync u_count_sync (
		.clk(clk),
		.arst_n(arst_n),
		.pin(count_pin_in),
		.level(),
		.fall(cpin_fall)
	);

	// control field decode
	assign rx_sel = ctl_reg[t3c_pkg::BIT_RECEIVE_CLOCK_SELECT];
	assign tx_sel = ctl_reg[t3c_pkg::BIT_TRANSMIT_CLOCK_SELECT];
	assign exen = ctl_reg[t3c_pkg::BIT_TRIGGER_INPUT_ENABLE];
	assign run = ctl_reg[t3c_pkg::BIT_RUN_CONTROL];
	assign cts = ctl_reg[t3c_pkg::BIT_COUNT_SOURCE_SELECT];
	assign cprl = ctl_reg[t3c_pkg::BIT_CAPTURE_RELOAD_SELECT];
	assign ud_en = mode_reg[t3c_pkg::BIT_UP_DOWN_ENABLE];
	assign ckoe = mode_reg[t3c_pkg::BIT_CLOCK_OUT_ENABLE];
	assign baud = rx_sel | tx_sel;
	assign serial_13 = serial_mode[0];

	// count events, overflow and trigger decode
	always_comb
	begin
		pre_tick = (pre_reg == t3c_pkg::PRESCALE_DIV - 4'h1);
		count_evt = run & (cts ? cpin_fall : pre_tick);
		dir_up = ~ud_en | trig_level;
		ovf = count_evt & dir_up & (cnt_reg == t3c_pkg::COUNT_ALL_ONES);
		unf = count_evt & ~dir_up & (cnt_reg == rcap_reg);
		trig_evt = trig_fall & exen & ~baud & ~ud_en;
		capture = trig_evt & cprl;
		reload = (ovf & (~cprl | baud)) | (trig_evt & ~cprl);
	end

	// prescaler for internal timing
	always_comb
	begin
		pre_next = pre_tick ? 4'h0 : pre_reg + 4'h1;
	end

	// control register: byte or bit write, hardware sets win over clears
	always_comb
	begin
		ctl_sw = ctl_reg;
		if (sfr_wr && sfr_addr == t3c_pkg::ADDR_CONTROL)
		begin
			ctl_sw = sfr_wdata;
		end
		else if (sfr_bit_wr && sfr_addr == t3c_pkg::ADDR_CONTROL)
		begin
			ctl_sw[sfr_bit_sel] = sfr_bit_val;
		end
		ctl_next = ctl_sw;
		if (ovf && !baud)
		begin
			ctl_next[t3c_pkg::BIT_OVERFLOW_FLAG] = 1'b1;
		end
		if (trig_evt)
		begin
			ctl_next[t3c_pkg::BIT_EXTERNAL_TRIGGER_FLAG] = 1'b1;
		end
		mode_next = mode_reg;
		if (sfr_wr && sfr_addr == t3c_pkg::ADDR_MODE)
		begin
			mode_next = sfr_wdata & t3c_pkg::MODE_IMPL_MASK;
		end
	end

	// counter and reload/capture bytes
	always_comb
	begin
		cnt_next = cnt_reg;
		rcap_next = rcap_reg;
		if (count_evt)
		begin
			cnt_next = dir_up ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001;
		end
		if (reload)
		begin
			cnt_next = rcap_reg;
		end
		else if (unf)
		begin
			cnt_next = t3c_pkg::COUNT_ALL_ONES;
		end
		if (sfr_wr && sfr_addr == t3c_pkg::ADDR_COUNT_LOW)
		begin
			cnt_next[7:0] = sfr_wdata;
		end
		if (sfr_wr && sfr_addr == t3c_pkg::ADDR_COUNT_HIGH)
		begin
			cnt_next[15:8] = sfr_wdata;
		end
		if (sfr_wr && sfr_addr == t3c_pkg::ADDR_RELOAD_LOW)
		begin
			rcap_next[7:0] = sfr_wdata;
		end
		if (sfr_wr && sfr_addr == t3c_pkg::ADDR_RELOAD_HIGH)
		begin
			rcap_next[15:8] = sfr_wdata;
		end
		if (capture)
		begin
			rcap_next = cnt_reg;
		end
	end

	// read data, baud ticks, interrupt and clock out
	always_comb
	begin
		rdata_next = rdata_reg;
		if (sfr_rd)
		begin
			case (sfr_addr)
				t3c_pkg::ADDR_CONTROL: rdata_next = ctl_reg;
				t3c_pkg::ADDR_MODE: rdata_next = mode_reg;
				t3c_pkg::ADDR_RELOAD_LOW: rdata_next = rcap_reg[7:0];
				t3c_pkg::ADDR_RELOAD_HIGH: rdata_next = rcap_reg[15:8];
				t3c_pkg::ADDR_COUNT_LOW: rdata_next = cnt_reg[7:0];
				t3c_pkg::ADDR_COUNT_HIGH: rdata_next = cnt_reg[15:8];
				default: rdata_next = 8'h00;
			endcase
		end
		rx_next = (rx_sel && serial_13) ? ovf : timer1_ovf;
		tx_next = (tx_sel && serial_13) ? ovf : timer1_ovf;
		irq_next = ctl_reg[t3c_pkg::BIT_OVERFLOW_FLAG]
			| (ctl_reg[t3c_pkg::BIT_EXTERNAL_TRIGGER_FLAG] & ~ud_en);
		cko_next = (ckoe && ovf) ? ~cko_reg : cko_reg;
	end

	// state registers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctl_reg <= t3c_pkg::RESET_CONTROL;
			mode_reg <= t3c_pkg::RESET_MODE;
			cnt_reg <= {t3c_pkg::RESET_BYTE, t3c_pkg::RESET_BYTE};
			rcap_reg <= {t3c_pkg::RESET_BYTE, t3c_pkg::RESET_BYTE};
			pre_reg <= 4'h0;
			rdata_reg <= 8'h00;
			rx_reg <= 1'b0;
			tx_reg <= 1'b0;
			irq_reg <= 1'b0;
			cko_reg <= 1'b0;
		end
		else
		begin
			ctl_reg <= ctl_next;
			mode_reg <= mode_next;
			cnt_reg <= cnt_next;
			rcap_reg <= rcap_next;
			pre_reg <= pre_next;
			rdata_reg <= rdata_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			irq_reg <= irq_next;
			cko_reg <= cko_next;
		end
	end

	// outputs straight from flip-flops
	assign sfr_rdata = rdata_reg;
	assign rx_baud_tick = rx_reg;
	assign tx_baud_tick = tx_reg;
	assign timer_irq = irq_reg;
	assign count_pin_out = cko_reg;
	assign count_pin_oe = ckoe;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	logic ctl_sw_write, ext_quiet, step_up, ext_step;
	logic [15:0] cnt_inc;
	assign ctl_sw_write = (sfr_wr | sfr_bit_wr) && sfr_addr == t3c_pkg::ADDR_CONTROL;
	assign ext_quiet = !ctl_reg[6] && !ctl_sw_write;
	assign step_up = dir_up & ~reload & ~sfr_wr;
	assign ext_step = run & cts & cpin_fall & step_up;
	assign cnt_inc = cnt_reg + 16'h0001;

	// flag and interrupt checks
	AST_OVF_SETS_FLAG: assert property (ovf && !baud |=> ctl_reg[7])
		else $error("overflow did not set overflow flag");
	AST_FLAG_STICKY: assert property (ctl_reg[7] && !ctl_sw_write |=> ctl_reg[7])
		else $error("overflow flag dropped without software");
	AST_NO_FLAG_BAUD: assert property (!ctl_reg[7] && !ctl_sw_write && baud |=> !ctl_reg[7])
		else $error("overflow flag set in baud mode");
	AST_TRIG_FLAG: assert property (trig_evt |=> ctl_reg[6])
		else $error("trigger event did not set external flag");
	AST_IRQ_OVF: assert property (ctl_reg[7] |=> timer_irq)
		else $error("overflow flag gave no interrupt");
	AST_IRQ_EXT: assert property (ctl_reg[6] && !ud_en |=> timer_irq)
		else $error("external flag gave no interrupt");
	AST_IRQ_UPDOWN: assert property (!ctl_reg[7] && ud_en |=> !timer_irq)
		else $error("interrupt raised in up/down mode");
	AST_TRIG_IGNORED: assert property (!exen |-> !trig_evt)
		else $error("trigger admitted while disabled");
	AST_EXEN: assert property (!exen && ext_quiet |=> !ctl_reg[6])
		else $error("external flag set while trigger disabled");
	AST_BAUD_EXT: assert property (baud && ext_quiet |=> !ctl_reg[6])
		else $error("external flag set while clocking serial port");

	// serial clock checks
	AST_RX_TICK: assert property (rx_sel && serial_13 |=> rx_baud_tick == $past(ovf))
		else $error("receive tick not from overflow");
	AST_RX_T1: assert property (!rx_sel |=> rx_baud_tick == $past(timer1_ovf))
		else $error("receive tick not from timer one");
	AST_TX_TICK: assert property (!tx_sel |=> tx_baud_tick == $past(timer1_ovf))
		else $error("transmit tick not from timer one");
	AST_TX_OVF: assert property (tx_sel && serial_13 |=> tx_baud_tick == $past(ovf))
		else $error("transmit tick not from overflow");

	// counter, reload, capture and clock out checks
	AST_STOPPED: assert property (!run && !sfr_wr && !reload |=> $stable(cnt_reg))
		else $error("counter moved while stopped");
	AST_STEP: assert property (count_evt && step_up |=> cnt_reg == $past(cnt_inc))
		else $error("counter did not step up by one");
	AST_EXT_STEP: assert property (ext_step |=> cnt_reg == $past(cnt_inc))
		else $error("count pin edge not counted");
	AST_CAPTURE: assert property (capture && !baud |=> rcap_reg == $past(cnt_reg))
		else $error("capture did not copy count");
	AST_RELOAD: assert property (reload && !sfr_wr |=> cnt_reg == $past(rcap_reg))
		else $error("reload did not load count");
	AST_OVFLD: assert property (ovf && !cprl && !sfr_wr |=> cnt_reg == $past(rcap_reg))
		else $error("overflow did not reload count");
	AST_BAUD_RELOAD: assert property (ovf && baud |-> reload)
		else $error("no reload on overflow in baud mode");
	AST_CKO: assert property (ckoe && ovf |=> count_pin_out != $past(count_pin_out))
		else $error("clock out did not toggle on overflow");

	// main scenarios
	COV_OVERFLOW: cover property (ovf && !baud);
	COV_CAPTURE: cover property (capture);
	COV_TRIG_RELOAD: cover property (trig_evt && !cprl);
	COV_BAUD: cover property (ovf && baud && serial_13);
	COV_EVENT_COUNT: cover property (count_evt && cts);
endmodule
`default_nettype wire

// ### hw/t3c_pkg.sv
// constants shared by the timer three capture/reload controller
package t3c_pkg;
	// special-function addresses
	localparam logic [7:0] ADDR_CONTROL = 8'hC8;
	localparam logic [7:0] ADDR_MODE = 8'hC9;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
	// control register bit positions
	localparam int BIT_OVERFLOW_FLAG = 7;
	localparam int BIT_EXTERNAL_TRIGGER_FLAG = 6;
	localparam int BIT_RECEIVE_CLOCK_SELECT = 5;
	localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
	localparam int BIT_TRIGGER_INPUT_ENABLE = 3;
	localparam int BIT_RUN_CONTROL = 2;
	localparam int BIT_COUNT_SOURCE_SELECT = 1;
	localparam int BIT_CAPTURE_RELOAD_SELECT = 0;
	// mode register bit positions
	localparam int BIT_UP_DOWN_ENABLE = 0;
	localparam int BIT_CLOCK_OUT_ENABLE = 1;
	localparam logic [7:0] MODE_IMPL_MASK = 8'h03;
	// reset values
	localparam logic [7:0] RESET_CONTROL = 8'h00;
	localparam logic [7:0] RESET_MODE = 8'h00;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// internal timing: one count per prescale period
	localparam logic [3:0] PRESCALE_DIV = 4'hC;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
endpackage

// ### hw/t3c_edge_sync.sv
// three-stage pin synchroniser with a filtered level and falling-edge pulse
`timescale 1ns/1ps
`default_nettype none
module t3c_edge_sync (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// asynchronous pin
	input wire logic pin,
	// synchronised outputs
	output logic level,
	output logic fall
);
	logic s1_reg, s2_reg, s3_reg, lvl_reg, fall_reg;
	logic lvl_next, fall_next;

	// a change is accepted once stages two and three agree
	always_comb
	begin
		lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
		fall_next = lvl_reg & (s2_reg == s3_reg) & ~s3_reg;
	end

	// synchroniser chain, resets to the idle-high pin level
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			lvl_reg <= 1'b1;
			fall_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
			fall_reg <= fall_next;
		end
	end

	assign level = lvl_reg;
	assign fall = fall_reg;
endmodule
`default_nettype wire

// ### test/t3c_partner.sv
// pin and timer 1 model on the far side of timer three
`timescale 1ns/1ps
`default_nettype none
module t3c_partner (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// commands from the bench
	input wire logic trig_go,
	input wire logic cnt_go,
	// pins and other timer
	output logic trigger_pin,
	output logic count_pin_in,
	output logic timer1_ovf
);
	logic [3:0] trig_reg;
	logic [3:0] cnt_reg;
	logic [3:0] t1_reg;
	// each command holds a pin low four cycles, then the pull-up returns it
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			trig_reg <= 4'h0;
			cnt_reg <= 4'h0;
			t1_reg <= 4'h0;
		end
		else
		begin
			trig_reg <= trig_go ? 4'h8 : trig_reg - 4'(trig_reg != 4'h0);
			cnt_reg <= cnt_go ? 4'h8 : cnt_reg - 4'(cnt_reg != 4'h0);
			t1_reg <= t1_reg + 4'h1;
		end
	end
	// pin levels and a free-running timer 1 overflow every 16 cycles
	assign trigger_pin = !(trig_reg > 4'h4);
	assign count_pin_in = !(cnt_reg > 4'h4);
	assign timer1_ovf = (t1_reg == 4'hF);
endmodule
`default_nettype wire

// ### test/test_timer2_capture_reload_ctrl.sv
// self-checking bench for the timer three capture/reload controller
`timescale 1ns/1ps
`default_nettype none
module test_timer2_capture_reload_ctrl;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
	logic [2:0] sfr_bit_sel = 3'h0;
	logic [1:0] serial_mode = 2'h1;
	logic trig_go = 1'b0, cnt_go = 1'b0;
	logic trigger_pin, count_pin_in, timer1_ovf, rx_baud_tick, tx_baud_tick, timer_irq;
	logic cko, cko_oe;
	logic [15:0] seed = 16'h0038, v, w;
	logic [7:0] d = 8'h00, lo;
	int mismatches = 0, cmp_count = 0, cycles = 0, rx_n = 0, tx_n = 0, r0, t0;
	// design and far-side model
	t3c_top dut (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel),
		.sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata), .trigger_pin(trigger_pin),
		.count_pin_in(count_pin_in), .count_pin_out(cko), .count_pin_oe(cko_oe),
		.serial_mode(serial_mode), .timer1_ovf(timer1_ovf), .rx_baud_tick(rx_baud_tick),
		.tx_baud_tick(tx_baud_tick), .timer_irq(timer_irq));
	t3c_partner far (.clk(clk), .arst_n(arst_n), .trig_go(trig_go), .cnt_go(cnt_go),
		.trigger_pin(trigger_pin), .count_pin_in(count_pin_in), .timer1_ovf(timer1_ovf));
	// clock, run-time ceiling and baud tick tally
	always #2.5 clk = ~clk;
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		rx_n <= rx_n + int'(rx_baud_tick === 1'b1);
		tx_n <= tx_n + int'(tx_baud_tick === 1'b1);
		if (cycles == 20000)
		begin
			mismatches++;
			stop_test();
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic stop_test();
		$display("counts: comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= x;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic ldw(input logic [7:0] a, input logic [15:0] x);
		wr(a, x[7:0]);
		wr(a + 8'h01, x[15:8]);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] x);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 x = sfr_rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] x;
		rd(a, x);
		chk({8'h00, x}, {8'h00, e});
	endtask
	task automatic pulse(input logic t);
		@(posedge clk);
		trig_go <= t;
		cnt_go <= !t;
		@(posedge clk);
		trig_go <= 1'b0;
		cnt_go <= 1'b0;
		repeat (14) @(posedge clk);
	endtask
	// scenarios
	initial
	begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		for (int a = 8'hC8; a <= 8'hCD; a++)
			rdc(8'(a), 8'h00);
		rdc(8'hC7, 8'h00);
		$display("reset values done");
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			v = seed;
			seed = lfsr(seed);
			w = seed;
			wr(8'hC8, {7'h04, i[0]});
			ldw(8'hCA, v);
			ldw(8'hCC, w);
			pulse(1'b1);
			rdc(8'hC8, {7'h24, i[0]});
			chk({15'h0000, timer_irq}, 16'h0001);
			rd(8'hCA, lo);
			rd(8'hCB, d);
			chk({d, lo}, i[0] ? w : v);
			rd(8'hCC, lo);
			rd(8'hCD, d);
			chk({d, lo}, i[0] ? w : v);
			wr(8'hC8, {7'h00, i[0]});
			pulse(1'b1);
			rdc(8'hC8, {7'h00, i[0]});
		end
		wr(8'hC8, 8'h09);
		pulse(1'b1);
		chk({15'h0000, timer_irq}, 16'h0001);
		wr(8'hC9, 8'h01);
		@(posedge clk);
		#1 chk({15'h0000, timer_irq}, 16'h0000);
		wr(8'hC9, 8'h03);
		rdc(8'hC9, 8'h03);
		chk({15'h0000, cko_oe}, 16'h0001);
		wr(8'hC9, 8'h00);
		@(posedge clk);
		#1 chk({15'h0000, cko_oe}, 16'h0000);
		$display("capture and reload done");
		ldw(8'hCA, 16'h1234);
		ldw(8'hCC, 16'hFFFE);
		wr(8'hC9, 8'h02);
		wr(8'hC8, 8'h04);
		d = 8'h00;
		for (int k = 0; k < 100 && d[7] !== 1'b1; k++)
			rd(8'hC8, d);
		chk({8'h00, d}, 16'h0084);
		chk({15'h0000, cko}, 16'h0001);
		rdc(8'hCD, 8'h12);
		chk({15'h0000, timer_irq}, 16'h0001);
		@(posedge clk);
		sfr_addr <= 8'hC8;
		sfr_bit_sel <= 3'h7;
		sfr_bit_wr <= 1'b1;
		@(posedge clk);
		sfr_bit_wr <= 1'b0;
		rdc(8'hC8, 8'h04);
		wr(8'hC9, 8'h00);
		wr(8'hC8, 8'h00);
		rd(8'hCC, lo);
		repeat (40) @(posedge clk);
		rdc(8'hCC, lo);
		$display("overflow and run done");
		ldw(8'hCC, 16'h0000);
		wr(8'hC8, 8'h06);
		repeat (2) pulse(1'b0);
		repeat (60) @(posedge clk);
		rdc(8'hCC, 8'h02);
		$display("event count done");
		ldw(8'hCA, 16'h8000);
		ldw(8'hCC, 16'hFFFE);
		wr(8'hC8, 8'h35);
		repeat (2) @(posedge clk);
		#1 r0 = rx_n;
		t0 = tx_n;
		repeat (60) @(posedge clk);
		rdc(8'hC8, 8'h35);
		rdc(8'hCD, 8'h80);
		chk(16'(rx_n - r0), 16'h0001);
		chk(16'(tx_n - t0), 16'h0001);
		wr(8'hC8, 8'h00);
		r0 = rx_n;
		t0 = tx_n;
		repeat (40) @(posedge clk);
		chk(16'((rx_n != r0) && (tx_n != t0)), 16'h0001);
		$display("serial clocks done");
		stop_test();
	end
endmodule
`default_nettype wire
